// *** logic/csd_params.svh ***
/*
  Constants of the camera serial command decoder: command codes, field
  positions, reset values and serial timing.
  Assumes inclusion by the package and by the design files.
*/
// Behaviour
// RQ1 - Mode write is a command byte then one data byte, applied after data.
// RQ2 - Hard reset code restores every register default, no data byte follows.
// RQ3 - Mode register written by one code, read back by another code.
// RQ4 - Mode bit 7 selects external integration, bit 3 external trigger, default 0.
// RQ5 - Bit 2 disables flushing; only meaningful while bit 7 selects external integration.
// RQ6 - Three write-only byte registers form the 24-bit exposure time.
// RQ7 - Camera type read returns a fixed 8-bit model identifier.
// RQ8 - Firmware read returns clock-board revision in the low nibble.
// RQ9 - Converter soft reset restarts that board's controller, both channels.
// RQ10 - Soft reset and hard reset are the only writes without a data byte.
// RQ11 - After soft reset the black level loop restarts, then settles near 50.
// RQ12 - Channel gain is 16 bits as high and low bytes; top 14 used.
// RQ13 - Each command set addresses the gain of a single converter channel.
// RQ14 - Host computes gain code as 32768 times log10 of gain, 1 to 10.
// RQ15 - Host writes both gain high and low bytes when changing gain.
// RQ16 - Gain read command returns stored high or low byte of that channel.
// RQ17 - Offset set point held per board, both channels, default 50 counts.
// RQ18 - Board set point write is its command code then one data byte.
// RQ19 - Converter command: bits 3:0 operation, 5:4 board, 6 read, 7 clock board.
// RQ20 - Bytes travel at 9600 baud, one start, eight data, no parity, one stop.
// RQ21 - Invalid binning pattern falls back to 1x1 in both directions.
// RQ22 - Mode bits 6:4 and 1 read zero; bit 0 is the serial trigger level.
// RQ23 - Binning: vertical bits 6:4, horizontal 2:0, one-hot 1x/2x/4x, default 1x.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// ----------------------------------------------------------------------
// Serial timing
// ----------------------------------------------------------------------
`define CSD_CLK_HZ          100000000
`define CSD_BAUD            9600
`define CSD_BIT_CYCLES      (`CSD_CLK_HZ / `CSD_BAUD)

// ----------------------------------------------------------------------
// Clock-board command codes
// ----------------------------------------------------------------------
`define CSD_CMD_HARD_RESET  8'h80
`define CSD_CMD_MODE_WR     8'h82
`define CSD_CMD_MODE_RD     8'hC2
`define CSD_CMD_BIN_WR      8'h85
`define CSD_CMD_EXP_LOW     8'h8A
`define CSD_CMD_EXP_MID     8'h8B
`define CSD_CMD_EXP_HIGH    8'h8C
`define CSD_CMD_TYPE_RD     8'hC3
`define CSD_CMD_FW_RD       8'hC5

// ----------------------------------------------------------------------
// Converter-board operations
// ----------------------------------------------------------------------
`define CSD_OP_SOFT_RESET   4'h0
`define CSD_OP_SETPOINT     4'hA
`define CSD_NUM_BOARDS      2
`define CSD_NUM_CHANNELS    4

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define CSD_MODE_EXT_INT    7
`define CSD_MODE_EXT_TRIG   3
`define CSD_MODE_NO_FLUSH   2
`define CSD_MODE_SER_TRIG   0
`define CSD_MODE_MASK       8'h8D

// ----------------------------------------------------------------------
// Binning fields and codes
// ----------------------------------------------------------------------
`define CSD_BIN_V_HI        6
`define CSD_BIN_V_LO        4
`define CSD_BIN_H_HI        2
`define CSD_BIN_H_LO        0
`define CSD_BIN_1X          3'h1
`define CSD_BIN_2X          3'h2
`define CSD_BIN_4X          3'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSD_MODE_RST        8'h00
`define CSD_BIN_RST         8'h11
`define CSD_EXP_LOW_RST     8'h2B
`define CSD_EXP_MID_RST     8'hFC
`define CSD_EXP_HIGH_RST    8'h00
`define CSD_GAIN_RST        16'h0000
`define CSD_SETPOINT_RST    8'h32
`define CSD_GAIN_USED       14

`endif

// *** logic/csd_pkg.sv ***
/*
  Types shared by the camera serial command decoder files.
  Assumes csd_params.svh is on the include path.
*/
`include "csd_params.svh"

package csd_pkg;

  // Command byte fields
  typedef struct packed {
    logic       clock_board;
    logic       is_read;
    logic [1:0] board;
    logic [3:0] op;
  } csd_cmd_t;

  // Configuration driven into the camera
  typedef struct packed {
    logic                                          ext_integrate;
    logic                                          ext_trigger;
    logic                                          flush_disable;
    logic                                          serial_trigger;
    logic [2:0]                                    vbin;
    logic [2:0]                                    hbin;
    logic [23:0]                                   exposure;
    logic [`CSD_NUM_CHANNELS-1:0][`CSD_GAIN_USED-1:0] gain;
    logic [`CSD_NUM_BOARDS-1:0][7:0]               setpoint;
    logic [`CSD_NUM_BOARDS-1:0]                    adc_restart;
  } csd_cfg_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} csd_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} csd_tx_state_t;
  typedef enum logic {DEC_IDLE, DEC_WAIT_DATA} csd_dec_state_t;

endpackage

// *** logic/csd_uart_rx.sv ***
/*
  Serial byte receiver, 8N1, for the command decoder.
  Assumes rxd is an asynchronous pin idling high.
*/
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_uart_rx #(
  parameter int BIT_CYCLES = `CSD_BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Serial pin
  input  wire logic       rxd,
  // Received byte
  output logic [7:0]      rx_data,
  output logic            rx_valid
);
  import csd_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);

  logic            sync1_reg;
  logic            sync2_reg;
  csd_rx_state_t   state_reg,  state_next;
  logic [CW-1:0]   cnt_reg,    cnt_next;
  logic [2:0]      bitn_reg,   bitn_next;
  logic [7:0]      shift_reg,  shift_next;
  logic [7:0]      data_reg,   data_next;
  logic            valid_reg,  valid_next;

  assign rx_data  = data_reg;
  assign rx_valid = valid_reg;

  // ----------------------------------------------------------------------
  // Frame sampling at mid-bit
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bitn_next  = bitn_reg;
    shift_next = shift_reg;
    data_next  = data_reg;
    valid_next = 1'b0;
    case (state_reg)
      RX_IDLE:
      begin
        if (!sync2_reg)
        begin
          state_next = RX_START;
          cnt_next   = CW'(BIT_CYCLES / 2);
        end
      end
      RX_START:
      begin
        if (cnt_reg == '0)
        begin
          // A glitch shorter than half a bit is not a start
          state_next = sync2_reg ? RX_IDLE : RX_DATA;
          cnt_next   = CW'(BIT_CYCLES - 1);
          bitn_next  = 3'h0;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      RX_DATA:
      begin
        if (cnt_reg == '0)
        begin
          shift_next = {sync2_reg, shift_reg[7:1]}; // RQ20
          cnt_next   = CW'(BIT_CYCLES - 1);
          bitn_next  = bitn_reg + 3'h1;
          if (bitn_reg == 3'h7)
            state_next = RX_STOP;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      RX_STOP:
      begin
        if (cnt_reg == '0)
        begin
          // Framing error drops the byte
          valid_next = sync2_reg; // RQ20
          data_next  = shift_reg;
          state_next = RX_IDLE;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default:
        state_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      bitn_reg  <= 3'h0;
      shift_reg <= 8'h00;
      data_reg  <= 8'h00;
      valid_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync1_reg <= rxd;
      sync2_reg <= sync1_reg;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bitn_reg  <= bitn_next;
      shift_reg <= shift_next;
      data_reg  <= data_next;
      valid_reg <= valid_next;
    end
  end

endmodule

// *** logic/csd_uart_tx.sv ***
/*
  Serial byte transmitter, 8N1, for read answers.
  Assumes tx_start is a one-cycle pulse taken only while tx_busy is low.
*/
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_uart_tx #(
  parameter int BIT_CYCLES = `CSD_BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Byte to send
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_start,
  output logic            tx_busy,
  // Serial pin
  output logic            txd
);
  import csd_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);

  csd_tx_state_t  state_reg, state_next;
  logic [CW-1:0]  cnt_reg,   cnt_next;
  logic [3:0]     bits_reg,  bits_next;
  logic [9:0]     frame_reg, frame_next;
  logic           txd_reg,   txd_next;

  assign tx_busy = (state_reg != TX_IDLE);
  assign txd     = txd_reg;

  // ----------------------------------------------------------------------
  // Shift out start, eight data bits LSB first, stop
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bits_next  = bits_reg;
    frame_next = frame_reg;
    txd_next   = txd_reg;
    case (state_reg)
      TX_IDLE:
      begin
        txd_next = 1'b1;
        if (tx_start)
        begin
          frame_next = {1'b1, tx_data, 1'b0}; // RQ20
          state_next = TX_SHIFT;
          cnt_next   = '0;
          bits_next  = 4'hA;
        end
      end
      TX_SHIFT:
      begin
        if (cnt_reg == '0)
        begin
          if (bits_reg == 4'h0)
            state_next = TX_IDLE;
          else
          begin
            txd_next   = frame_reg[0];
            frame_next = {1'b1, frame_reg[9:1]};
            bits_next  = bits_reg - 4'h1;
            cnt_next   = CW'(BIT_CYCLES - 1);
          end
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default:
        state_next = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= TX_IDLE;
      cnt_reg   <= '0;
      bits_reg  <= 4'h0;
      frame_reg <= 10'h3FF;
      txd_reg   <= 1'b1;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bits_reg  <= bits_next;
      frame_reg <= frame_next;
      txd_reg   <= txd_next;
    end
  end

endmodule

// *** logic/csd_top.sv ***
/*
  Camera serial command decoder: takes command and value bytes from the
  host serial line, holds the clock-board and converter-board settings
  and answers read commands on the same serial line.
  Assumes one 100 MHz clock, a synchronous reset at power-up and a host
  that keeps to one command at a time.
*/
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_top #(
  parameter int        BIT_CYCLES = `CSD_BIT_CYCLES,
  parameter logic [7:0] MODEL_ID   = 8'hA5,   // Arbitrary value
  parameter logic [3:0] FW_REV     = 4'h1     // Arbitrary value
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Serial line
  input  wire logic       serial_rxd,
  output logic            serial_txd,
  // Camera settings
  output csd_pkg::csd_cfg_t cfg
);
  import csd_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Only 1x, 2x and 4x are legal
  function automatic logic bin_code_ok(input logic [2:0] code);
    bin_code_ok = (code == `CSD_BIN_1X) || (code == `CSD_BIN_2X)
                  || (code == `CSD_BIN_4X);
  endfunction

  // Any bad field sends both directions back to 1x
  function automatic logic [7:0] bin_filter(input logic [7:0] raw);
    logic [7:0] res;
    res = 8'h00;
    if (bin_code_ok(raw[`CSD_BIN_V_HI:`CSD_BIN_V_LO])
        && bin_code_ok(raw[`CSD_BIN_H_HI:`CSD_BIN_H_LO]))
    begin
      res[`CSD_BIN_V_HI:`CSD_BIN_V_LO] = raw[`CSD_BIN_V_HI:`CSD_BIN_V_LO];
      res[`CSD_BIN_H_HI:`CSD_BIN_H_LO] = raw[`CSD_BIN_H_HI:`CSD_BIN_H_LO];
    end
    else
      res = `CSD_BIN_RST;
    bin_filter = res;
  endfunction

  // Ops 2, 3, 6, 7: gain bytes
  function automatic logic is_gain_op(input logic [3:0] op);
    is_gain_op = !op[3] && op[1];
  endfunction

  // Channel A/B on board 0, C/D on board 1; op bit 2 picks the second channel
  function automatic logic [1:0] gain_chan(input csd_cmd_t c);
    gain_chan = {c.board[0], c.op[2]};
  endfunction

  function automatic logic board_ok(input logic [1:0] b);
    board_ok = (b < 2'(`CSD_NUM_BOARDS));
  endfunction

  function automatic logic is_setpoint_op(input logic [3:0] op);
    is_setpoint_op = (op == `CSD_OP_SETPOINT);
  endfunction

  // ----------------------------------------------------------------------
  // Serial byte links
  // ----------------------------------------------------------------------
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       tx_busy;

  csd_dec_state_t                        state_reg,    state_next;
  csd_cmd_t                              cmd_reg,      cmd_next;
  logic [7:0]                            mode_reg,     mode_next;
  logic [7:0]                            bin_reg,      bin_next;
  logic [7:0]                            exp_low_reg,  exp_low_next;
  logic [7:0]                            exp_mid_reg,  exp_mid_next;
  logic [7:0]                            exp_high_reg, exp_high_next;
  logic [`CSD_NUM_CHANNELS-1:0][15:0]    gain_reg,     gain_next;
  logic [`CSD_NUM_BOARDS-1:0][7:0]       setpt_reg,    setpt_next;
  logic [`CSD_NUM_BOARDS-1:0]            restart_reg,  restart_next;
  logic [7:0]                            tx_byte_reg,  tx_byte_next;
  logic                                  tx_go_reg,    tx_go_next;
  csd_cfg_t                              cfg_reg,      cfg_next;
  csd_cmd_t                              rx_cmd;

  assign rx_cmd = csd_cmd_t'(rx_data); // RQ19
  assign cfg    = cfg_reg;

  csd_uart_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .rxd      (serial_rxd),
    .rx_data  (rx_data),
    .rx_valid (rx_valid)
  );

  csd_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .tx_data  (tx_byte_reg),
    .tx_start (tx_go_reg),
    .tx_busy  (tx_busy),
    .txd      (serial_txd)
  );

  // ----------------------------------------------------------------------
  // Command interpreter
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    mode_next     = mode_reg;
    bin_next      = bin_reg;
    exp_low_next  = exp_low_reg;
    exp_mid_next  = exp_mid_reg;
    exp_high_next = exp_high_reg;
    gain_next     = gain_reg;
    setpt_next    = setpt_reg;
    restart_next  = '0;
    tx_byte_next  = tx_byte_reg;
    tx_go_next    = 1'b0;
    if (rx_valid)
    begin
      case (state_reg)
        DEC_IDLE:
        begin
          if (rx_data == `CSD_CMD_HARD_RESET)
          begin
            // No data byte follows; loops restart too
            mode_next     = `CSD_MODE_RST; // RQ2 RQ10
            bin_next      = `CSD_BIN_RST; // RQ2
            exp_low_next  = `CSD_EXP_LOW_RST; // RQ2
            exp_mid_next  = `CSD_EXP_MID_RST; // RQ2
            exp_high_next = `CSD_EXP_HIGH_RST; // RQ2
            gain_next     = {`CSD_NUM_CHANNELS{`CSD_GAIN_RST}}; // RQ2
            setpt_next    = {`CSD_NUM_BOARDS{`CSD_SETPOINT_RST}}; // RQ2
            restart_next  = '1; // RQ2
          end
          else if (rx_cmd.clock_board)
          begin
            if (rx_cmd.is_read)
            begin
              // A read that finds the line busy is dropped, not queued
              tx_go_next = !tx_busy;
              case (rx_data)
                `CSD_CMD_MODE_RD: tx_byte_next = mode_reg; // RQ3
                `CSD_CMD_TYPE_RD: tx_byte_next = MODEL_ID; // RQ7
                `CSD_CMD_FW_RD:   tx_byte_next = {4'h0, FW_REV}; // RQ8
                default:          tx_go_next   = 1'b0;
              endcase
            end
            else
            begin
              state_next = DEC_WAIT_DATA; // RQ1
              cmd_next   = rx_cmd;
            end
          end
          else if (rx_cmd.is_read)
          begin
            // Absent boards get no answer
            if (board_ok(rx_cmd.board) && !tx_busy)
            begin
              if (is_gain_op(rx_cmd.op))
              begin
                tx_go_next   = 1'b1; // RQ16
                tx_byte_next = rx_cmd.op[0] ? gain_reg[gain_chan(rx_cmd)][15:8]
                                            : gain_reg[gain_chan(rx_cmd)][7:0]; // RQ16
              end
              else if (is_setpoint_op(rx_cmd.op))
              begin
                tx_go_next   = 1'b1;
                tx_byte_next = setpt_reg[rx_cmd.board[0]];
              end
            end
          end
          else if (rx_cmd.op == `CSD_OP_SOFT_RESET)
          begin
            if (board_ok(rx_cmd.board))
              restart_next[rx_cmd.board[0]] = 1'b1; // RQ9 RQ10 RQ11
          end
          else
          begin
            // Unlisted writes still eat their data byte to keep pairing
            state_next = DEC_WAIT_DATA; // RQ10
            cmd_next   = rx_cmd;
          end
        end
        DEC_WAIT_DATA:
        begin
          // Even 80h is plain data here
          state_next = DEC_IDLE;
          if (cmd_reg.clock_board)
          begin
            case (8'(cmd_reg))
              `CSD_CMD_MODE_WR:  mode_next     = rx_data & `CSD_MODE_MASK; // RQ1 RQ22
              `CSD_CMD_BIN_WR:   bin_next      = bin_filter(rx_data); // RQ21 RQ23
              `CSD_CMD_EXP_LOW:  exp_low_next  = rx_data; // RQ6
              `CSD_CMD_EXP_MID:  exp_mid_next  = rx_data; // RQ6
              `CSD_CMD_EXP_HIGH: exp_high_next = rx_data; // RQ6
              default:           mode_next     = mode_reg;
            endcase
          end
          // Absent boards drop their data
          else if (board_ok(cmd_reg.board))
          begin
            if (is_gain_op(cmd_reg.op))
            begin
              if (cmd_reg.op[0])
                gain_next[gain_chan(cmd_reg)][15:8] = rx_data; // RQ12 RQ13
              else
                gain_next[gain_chan(cmd_reg)][7:0] = rx_data; // RQ12 RQ13
            end
            else if (is_setpoint_op(cmd_reg.op))
              setpt_next[cmd_reg.board[0]] = rx_data; // RQ17 RQ18
          end
        end
        default:
          state_next = DEC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered camera settings
  // ----------------------------------------------------------------------
  always_comb
  begin
    cfg_next                = cfg_reg;
    cfg_next.ext_integrate  = mode_reg[`CSD_MODE_EXT_INT]; // RQ4
    cfg_next.ext_trigger    = mode_reg[`CSD_MODE_EXT_TRIG]; // RQ4
    // Flush can only be skipped under external integration
    cfg_next.flush_disable  = mode_reg[`CSD_MODE_NO_FLUSH]
                              && mode_reg[`CSD_MODE_EXT_INT]; // RQ5
    cfg_next.serial_trigger = mode_reg[`CSD_MODE_SER_TRIG]; // RQ22
    cfg_next.vbin           = bin_reg[`CSD_BIN_V_HI:`CSD_BIN_V_LO]; // RQ23
    cfg_next.hbin           = bin_reg[`CSD_BIN_H_HI:`CSD_BIN_H_LO]; // RQ23
    cfg_next.exposure       = {exp_high_reg, exp_mid_reg, exp_low_reg}; // RQ6
    for (int i = 0; i < `CSD_NUM_CHANNELS; i++)
    begin
      cfg_next.gain[i] = gain_reg[i][15:16-`CSD_GAIN_USED]; // RQ12
    end
    cfg_next.setpoint       = setpt_reg; // RQ17
    cfg_next.adc_restart    = restart_reg; // RQ9 RQ11
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg    <= DEC_IDLE;
      cmd_reg      <= '0;
      mode_reg     <= `CSD_MODE_RST;
      bin_reg      <= `CSD_BIN_RST;
      exp_low_reg  <= `CSD_EXP_LOW_RST;
      exp_mid_reg  <= `CSD_EXP_MID_RST;
      exp_high_reg <= `CSD_EXP_HIGH_RST;
      gain_reg     <= {`CSD_NUM_CHANNELS{`CSD_GAIN_RST}};
      setpt_reg    <= {`CSD_NUM_BOARDS{`CSD_SETPOINT_RST}};
      restart_reg  <= '0;
      tx_byte_reg  <= 8'h00;
      tx_go_reg    <= 1'b0;
    end
    else if (ce)
    begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      mode_reg     <= mode_next;
      bin_reg      <= bin_next;
      exp_low_reg  <= exp_low_next;
      exp_mid_reg  <= exp_mid_next;
      exp_high_reg <= exp_high_next;
      gain_reg     <= gain_next;
      setpt_reg    <= setpt_next;
      restart_reg  <= restart_next;
      tx_byte_reg  <= tx_byte_next;
      tx_go_reg    <= tx_go_next;
    end
  end

  // Keeps every output a flop
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cfg_reg <= '0;
    else if (ce)
      cfg_reg <= cfg_next;
  end

endmodule

// *** bench/csd_checker.sv ***
/*
  Port checker of the serial command decoder.
  Assumes bind onto csd_top and an idle-high host line.
*/
`timescale 1ns/1ps
module csd_checker #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              serial_rxd,
  input wire logic              serial_txd,
  input wire csd_pkg::csd_cfg_t cfg
);
  import csd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Settling counter, cfg shows zeros just after reset
  logic [2:0] up_reg;
  logic [2:0] up_next;
  always_comb up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  always_ff @(posedge core_clk) up_reg <= rst ? 3'h0 : up_next;
  sequence s_low8; !serial_txd[*8]; endsequence
  property p_start; $fell(serial_txd) |-> s_low8; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_vbin; up_reg == 3'h7 |-> cfg.vbin inside {3'h1, 3'h2, 3'h4}; endproperty
  a_vbin: assert property (p_vbin) else $error("vertical bin not one-hot");
  property p_hbin; up_reg == 3'h7 |-> cfg.hbin inside {3'h1, 3'h2, 3'h4}; endproperty
  a_hbin: assert property (p_hbin) else $error("horizontal bin not one-hot");
  property p_flush; cfg.flush_disable |-> cfg.ext_integrate; endproperty
  a_flush: assert property (p_flush) else $error("flush off in internal mode");
  property p_pulse; |cfg.adc_restart |=> cfg.adc_restart == 2'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("restart pulse too long");
  // Answers and updates only follow a received stop bit
  property p_answer; $fell(serial_txd) |-> $past(serial_rxd, 3); endproperty
  a_answer: assert property (p_answer) else $error("answer without request");
  property p_exp; up_reg == 3'h7 && $changed(cfg.exposure) |-> $past(serial_rxd, 4); endproperty
  a_exp: assert property (p_exp) else $error("exposure changed unasked");
  property p_set; up_reg == 3'h7 && $changed(cfg.setpoint) |-> $past(serial_rxd, 4); endproperty
  a_set: assert property (p_set) else $error("set point changed unasked");
endmodule

bind csd_top csd_checker #(.BIT_CYCLES(BIT_CYCLES)) csd_checker_inst (.core_clk(core_clk), .rst(rst), .ce(ce),
  .serial_rxd(serial_rxd), .serial_txd(serial_txd), .cfg(cfg));

// *** bench/csd_host.sv ***
/*
  Host model: sends and receives 8N1 bytes on the serial line.
  Assumes calls start on a rising clock edge.
*/
`timescale 1ns/1ps
module csd_host #(
  parameter int BIT = 16
) (
  input  wire logic core_clk,
  input  wire logic serial_txd,
  output logic      serial_rxd
);
  initial serial_rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_rxd <= f[i];
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  // Samples mid-bit, so a one-cycle skew on detection is harmless
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (serial_txd !== 1'b0 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    ok = (n < 400);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge core_clk);
      b[i] = serial_txd;
    end
    repeat (BIT) @(posedge core_clk);
    ok = ok && (serial_txd === 1'b1);
  endtask
endmodule

// *** bench/test_csd_top.sv ***
/*
  Self-checking bench of the decoder through its serial line.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module test_csd_top;
  import csd_pkg::*;
  logic     core_clk = 1'b0;
  logic     rst = 1'b1;
  logic     ce = 1'b1;
  logic     clr = 1'b0;
  logic     serial_rxd;
  logic     serial_txd;
  logic [1:0] seen;
  csd_cfg_t cfg;
  int       fail_count = 0;
  int       comparisons = 0;
  // Identity values are arbitrary
  csd_top #(.BIT_CYCLES(16), .MODEL_ID(8'h5A), .FW_REV(4'h6)) csd_top_inst (.core_clk(core_clk), .rst(rst),
    .ce(ce), .serial_rxd(serial_rxd), .serial_txd(serial_txd), .cfg(cfg));
  csd_host #(.BIT(16)) csd_host_inst (.core_clk(core_clk), .serial_txd(serial_txd), .serial_rxd(serial_rxd));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) seen <= (rst || clr) ? 2'h0 : seen | cfg.adc_restart;
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    csd_host_inst.send(c);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    csd_host_inst.send(c);
    cmd(d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] b;
    logic       ok;
    fork
      csd_host_inst.send(c);
      csd_host_inst.recv(b, ok);
    join
    chk(b & m, exp);
    chk(ok, 1'b1);
  endtask
  task automatic dflt();
    chk({cfg.ext_integrate, cfg.ext_trigger, cfg.flush_disable, cfg.serial_trigger}, 4'h0);
    chk({cfg.vbin, cfg.hbin}, 6'h09);
    chk(cfg.exposure, 24'h00FC2B);
    chk(cfg.setpoint, 16'h3232);
    chk(cfg.gain[1], 14'h0000);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    dflt();
    rd(8'hC2, 8'hFF, 8'h00);
    wr(8'h82, 8'hFF);
    chk({cfg.ext_integrate, cfg.ext_trigger, cfg.flush_disable, cfg.serial_trigger}, 4'hF);
    rd(8'hC2, 8'hFF, 8'h8D);
    wr(8'h82, 8'h04);
    chk(cfg.flush_disable, 1'b0);
    $display("Test mode done");
    wr(8'h8A, 8'h11);
    wr(8'h8B, 8'h22);
    wr(8'h8C, 8'h33);
    chk(cfg.exposure, 24'h332211);
    wr(8'h85, 8'h24);
    chk({cfg.vbin, cfg.hbin}, 6'h14);
    wr(8'h85, 8'h33);
    chk({cfg.vbin, cfg.hbin}, 6'h09);
    $display("Test timing and binning done");
    wr(8'h07, 8'h59);
    wr(8'h06, 8'h77);
    chk(cfg.gain[1], 14'h165D);
    chk(cfg.gain[0], 14'h0000);
    rd(8'h47, 8'hFF, 8'h59);
    rd(8'h46, 8'hFF, 8'h77);
    wr(8'h0A, 8'h20);
    chk(cfg.setpoint, 16'h3220);
    rd(8'hC3, 8'hFF, 8'h5A);
    rd(8'hC5, 8'h0F, 8'h06);
    $display("Test converter and identity done");
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    cmd(8'h10);
    wr(8'h0A, 8'h40);
    chk(seen, 2'h2);
    chk(cfg.setpoint, 16'h3240);
    cmd(8'h80);
    rd(8'hC2, 8'hFF, 8'h00);
    dflt();
    chk(seen, 2'h3);
    $display("Test resets done");
    finish_test();
  end
  // Whole run needs about 6000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
endmodule
